/* File: core/bame_pkg.sv */
// Purpose: Constants for the bus address match and end-of-string block
// Assumes: Byte-wide register port, one clock
// Notes: Offsets are port offsets inside the controller window
package bame_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [8:0] BAME_OFF_SECOND_SLOT = 9'h11f;
   localparam logic [8:0] BAME_OFF_EOS_BYTE = 9'h11f;
   localparam logic [8:0] BAME_OFF_FIRST_SLOT = 9'h11d;
   localparam logic [8:0] BAME_OFF_ADDR_LOAD = 9'h11c;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int BAME_BIT_SLOT_SELECT = 7;
   localparam int BAME_BIT_TALK_DIS = 6;
   localparam int BAME_BIT_LISTEN_DIS = 5;
   localparam int BAME_BIT_EOI = 7;
   localparam int BAME_BIT_EIGHT_BIT = 4;
   localparam int BAME_BIT_RX_EOS = 2;
   localparam int BAME_BIT_TX_EOS = 3;
   // ****************************************************************
   // Address offsets and reset values
   // ****************************************************************
   localparam logic [7:0] BAME_TALK_BASE = 8'h40;
   localparam logic [7:0] BAME_LISTEN_BASE = 8'h20;
   localparam logic [7:0] BAME_SECOND_BASE = 8'ha0;
   localparam logic [6:0] BAME_SLOT_RESET = 7'h60;
   localparam logic [7:0] BAME_EOS_RESET = 8'h00;
   // ****************************************************************
   // Addressing modes
   // ****************************************************************
   localparam logic [1:0] BAME_MODE_DUAL_A = 2'h1;
   localparam logic [1:0] BAME_MODE_SECONDARY = 2'h2;
   localparam logic [1:0] BAME_MODE_DUAL_B = 2'h3;
endpackage

/* File: core/bame_slot.sv */
// Purpose: One address slot with its match decode
// Assumes: Command byte is valid when cmd_valid is high
// Notes: Used twice by the top
`timescale 1ns/10ps
module bame_slot
   import bame_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Load
   input wire logic load,
   input wire logic [6:0] load_data,
   // Compare
   input wire logic [7:0] cmd_byte,
   // Result
   output logic [6:0] slot_reg,
   output logic talk_hit,
   output logic listen_hit,
   output logic second_hit
);
   wire logic [7:0] addr_ext;
   assign addr_ext = {3'h0, slot_reg[4:0]};
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slot_reg <= BAME_SLOT_RESET;
      end else if (clk_en && load) begin
         slot_reg <= load_data;
      end
   end
   assign talk_hit = !slot_reg[BAME_BIT_TALK_DIS] &&
      cmd_byte == BAME_TALK_BASE + addr_ext;
   assign listen_hit = !slot_reg[BAME_BIT_LISTEN_DIS] &&
      cmd_byte == BAME_LISTEN_BASE + addr_ext;
   assign second_hit = cmd_byte == BAME_SECOND_BASE + addr_ext;
endmodule

/* File: core/bame_top.sv */
// Purpose: Address recognition and end-of-string compare
// Assumes: Bus handshake strobes are synchronous one-cycle pulses
// Notes: Readback slots shown on register ports, updated each cycle
//
// Behaviour
// - Load bit 7 picks slot; low seven bits stored into it.
// - Talk disable bit blocks talk address recognition for its slot.
// - Listen disable bit blocks listen address recognition for its slot.
// - Talk address is bits plus 40, listen is bits plus 20.
// - Mode 2 second slot is secondary; modes 1, 3 minor primary.
// - Second talk disable blocks; else secondary checked only in TPAS.
// - Second listen disable blocks; else secondary checked only in LPAS.
// - Secondary is bits plus A0; minor talk 40, listen 20.
// - EOS byte compared; eight-bit compare bit picks 7 or 8 bits.
// - Listener with receive EOS sets end flag on received match.
// - Talker with transmit EOS asserts EOI with matching out byte.
// - First slot readable with disables and address bits.
`timescale 1ns/10ps
module bame_top
   import bame_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic chip_reset_cmd,
   // Register port
   input wire logic reg_wr,
   input wire logic [8:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // Auxiliary settings
   input wire logic [1:0] addr_mode,
   input wire logic [7:0] auxiliary_reg_a,
   // Bus side
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic byte_accepted,
   input wire logic [7:0] data_in_byte,
   input wire logic eoi_line,
   input wire logic listener_addressed,
   input wire logic talker_active,
   input wire logic tpas_state,
   input wire logic lpas_state,
   input wire logic out_valid,
   input wire logic [7:0] data_out_byte,
   // Readback
   output logic [7:0] first_address_slot,
   output logic [7:0] second_address_slot,
   // Results
   output logic major_talk_match,
   output logic major_listen_match,
   output logic minor_talk_match,
   output logic minor_listen_match,
   output logic secondary_talk_match,
   output logic secondary_listen_match,
   output logic end_flag_set,
   output logic eoi_n_out
);
   // ****************************************************************
   // Register decode
   // ****************************************************************
   logic [6:0] slot0;
   logic [6:0] slot1;
   logic eoi_reg;
   logic [7:0] eos_reg;
   wire logic load_wr;
   wire logic load0;
   wire logic load1;
   wire logic eos_wr;
   assign load_wr = reg_wr && reg_addr == BAME_OFF_ADDR_LOAD;
   assign load0 = load_wr && !reg_wdata[BAME_BIT_SLOT_SELECT];
   assign load1 = load_wr && reg_wdata[BAME_BIT_SLOT_SELECT];
   assign eos_wr = reg_wr && reg_addr == BAME_OFF_EOS_BYTE;
   // ****************************************************************
   // Slots
   // ****************************************************************
   wire logic t0;
   wire logic l0;
   wire logic t1;
   wire logic l1;
   wire logic s1;
   bame_slot u_slot0 (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .load(load0),
      .load_data(reg_wdata[6:0]),
      .cmd_byte(cmd_byte),
      .slot_reg(slot0),
      .talk_hit(t0),
      .listen_hit(l0),
      .second_hit()
   );
   bame_slot u_slot1 (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .load(load1),
      .load_data(reg_wdata[6:0]),
      .cmd_byte(cmd_byte),
      .slot_reg(slot1),
      .talk_hit(t1),
      .listen_hit(l1),
      .second_hit(s1)
   );
   // ****************************************************************
   // Match decode
   // ****************************************************************
   wire logic mode_sec;
   wire logic mode_dual;
   wire logic sec_t;
   wire logic sec_l;
   assign mode_sec = addr_mode == BAME_MODE_SECONDARY;
   assign mode_dual = addr_mode == BAME_MODE_DUAL_A ||
      addr_mode == BAME_MODE_DUAL_B;
   assign sec_t = mode_sec && s1 && tpas_state &&
      !slot1[BAME_BIT_TALK_DIS];
   assign sec_l = mode_sec && s1 && lpas_state &&
      !slot1[BAME_BIT_LISTEN_DIS];
   // ****************************************************************
   // End of string compare
   // ****************************************************************
   wire logic eight;
   wire logic rx_eq;
   wire logic tx_eq;
   assign eight = auxiliary_reg_a[BAME_BIT_EIGHT_BIT];
   assign rx_eq = eight ? data_in_byte == eos_reg :
      data_in_byte[6:0] == eos_reg[6:0];
   assign tx_eq = eight ? data_out_byte == eos_reg :
      data_out_byte[6:0] == eos_reg[6:0];
   wire logic rx_end;
   wire logic tx_end;
   assign rx_end = byte_accepted && listener_addressed &&
      auxiliary_reg_a[BAME_BIT_RX_EOS] && rx_eq;
   assign tx_end = out_valid && talker_active &&
      auxiliary_reg_a[BAME_BIT_TX_EOS] && tx_eq;
   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         eos_reg <= BAME_EOS_RESET;
      end else if (clk_en && eos_wr) begin
         eos_reg <= reg_wdata;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst || (clk_en && chip_reset_cmd)) begin
         eoi_reg <= 1'b0;
      end else if (clk_en && byte_accepted) begin
         eoi_reg <= eoi_line;
      end
   end
   // ****************************************************************
   // Output next values
   // ****************************************************************
   wire logic [7:0] first_slot_next;
   wire logic [7:0] second_slot_next;
   wire logic major_talk_next;
   wire logic major_listen_next;
   wire logic minor_talk_next;
   wire logic minor_listen_next;
   wire logic sec_talk_next;
   wire logic sec_listen_next;
   wire logic end_flag_next;
   wire logic eoi_n_next;
   assign first_slot_next = {1'b0, slot0};
   assign second_slot_next = {eoi_reg, slot1};
   assign major_talk_next = cmd_valid && t0;
   assign major_listen_next = cmd_valid && l0;
   assign minor_talk_next = cmd_valid && mode_dual && t1;
   assign minor_listen_next = cmd_valid && mode_dual && l1;
   assign sec_talk_next = cmd_valid && sec_t;
   assign sec_listen_next = cmd_valid && sec_l;
   assign end_flag_next = rx_end;
   assign eoi_n_next = !tx_end;
   // ****************************************************************
   // Readback registers
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         first_address_slot <= {1'b0, BAME_SLOT_RESET};
         second_address_slot <= {1'b0, BAME_SLOT_RESET};
      end else if (clk_en) begin
         first_address_slot <= first_slot_next;
         second_address_slot <= second_slot_next;
      end
   end
   // ****************************************************************
   // Match result registers
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         major_talk_match <= 1'b0;
         major_listen_match <= 1'b0;
         minor_talk_match <= 1'b0;
         minor_listen_match <= 1'b0;
      end else if (clk_en) begin
         major_talk_match <= major_talk_next;
         major_listen_match <= major_listen_next;
         minor_talk_match <= minor_talk_next;
         minor_listen_match <= minor_listen_next;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         secondary_talk_match <= 1'b0;
         secondary_listen_match <= 1'b0;
      end else if (clk_en) begin
         secondary_talk_match <= sec_talk_next;
         secondary_listen_match <= sec_listen_next;
      end
   end
   // ****************************************************************
   // End of string result registers
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         end_flag_set <= 1'b0;
         eoi_n_out <= 1'b1;
      end else if (clk_en) begin
         end_flag_set <= end_flag_next;
         eoi_n_out <= eoi_n_next;
      end
   end
endmodule

/* File: tb/bame_top_properties.sv */
// Purpose: Port checker for bame_top
// Assumes: Sees top ports only
// Notes: Bind at foot
`timescale 1ns/10ps
module bame_top_properties
   import bame_pkg::*;
(
   // Control
   input wire logic sys_clk, rst, clk_en, chip_reset_cmd, reg_wr,
   input wire logic [8:0] reg_addr,
   input wire logic [7:0] reg_wdata, auxiliary_reg_a, cmd_byte,
   input wire logic [7:0] data_in_byte, data_out_byte,
   input wire logic [1:0] addr_mode,
   input wire logic cmd_valid, byte_accepted, eoi_line, out_valid,
   input wire logic listener_addressed, talker_active, tpas_state,
   input wire logic lpas_state,
   // Results
   input wire logic [7:0] first_address_slot, second_address_slot,
   input wire logic major_talk_match, major_listen_match,
   input wire logic minor_talk_match, secondary_talk_match,
   input wire logic secondary_listen_match, end_flag_set, eoi_n_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [7:0] eos;
   wire [7:0] fs = first_address_slot;
   wire [7:0] ss = second_address_slot;
   wire [7:0] a0 = {3'h0, fs[4:0]};
   wire [7:0] a1 = {3'h0, ss[4:0]};
   wire eq_in = auxiliary_reg_a[4] ? data_in_byte == eos
      : data_in_byte[6:0] == eos[6:0];
   wire eq_out = auxiliary_reg_a[4] ? data_out_byte == eos
      : data_out_byte[6:0] == eos[6:0];
   wire q = cmd_valid && clk_en;
   // Shadow of the end-of-string byte
   always_ff @(posedge sys_clk) begin
      if (rst) eos <= BAME_EOS_RESET;
      else if (clk_en && reg_wr && reg_addr == BAME_OFF_EOS_BYTE)
         eos <= reg_wdata;
   end
   AST_MAJOR_TALK: assert property (
      q && !$past(reg_wr) && !fs[6]
      && cmd_byte == BAME_TALK_BASE + a0 |=> major_talk_match)
      else $error("major talk match missing");
   AST_MAJOR_LISTEN: assert property (
      major_listen_match && !$past(reg_wr, 2) |-> $past(cmd_valid)
      && !$past(fs[5]) && $past(cmd_byte) == BAME_LISTEN_BASE + $past(a0))
      else $error("major listen match unexpected");
   AST_MINOR_TALK: assert property (
      q && !$past(reg_wr) && addr_mode[0]
      && cmd_byte == BAME_TALK_BASE + a1 |=> minor_talk_match == !ss[6])
      else $error("minor talk match wrong");
   AST_SEC_TALK: assert property (
      q && !$past(reg_wr) && addr_mode == BAME_MODE_SECONDARY
      && cmd_byte == BAME_SECOND_BASE + a1 |=> secondary_talk_match
      == ($past(tpas_state) && !ss[6]))
      else $error("secondary talk match wrong");
   AST_SEC_LISTEN: assert property (
      secondary_listen_match |-> $past(lpas_state) && $past(cmd_valid))
      else $error("secondary listen outside addressed state");
   AST_END_FLAG: assert property (
      byte_accepted && clk_en && listener_addressed && auxiliary_reg_a[2]
      |=> end_flag_set == $past(eq_in))
      else $error("end flag wrong");
   AST_EOI_OUT: assert property (
      out_valid && clk_en && talker_active && auxiliary_reg_a[3]
      |=> eoi_n_out == !$past(eq_out))
      else $error("outgoing end wrong");
   AST_EOI_LATCH: assert property (
      byte_accepted && clk_en && !chip_reset_cmd ##1 !byte_accepted
      && clk_en |=> ss[7] == $past(eoi_line, 2))
      else $error("latched end bit wrong");
   cover property (major_talk_match);
   cover property (secondary_listen_match);
   cover property (end_flag_set);
   cover property (!eoi_n_out);
endmodule
bind bame_top bame_top_properties chk (.*);

/* File: tb/bame_bus_model.sv */
// Purpose: Other instruments on the bus
// Assumes: Strobes driven at falling edge
// Notes: Released lines show inverted data
`timescale 1ns/10ps
module bame_bus_model (
   // Clock
   input wire logic sys_clk,
   // Toward the block
   output logic cmd_valid = 1'b0,
   output logic [7:0] cmd_byte = 8'h00,
   output logic byte_accepted = 1'b0,
   output logic [7:0] data_in_byte = 8'h00,
   output logic eoi_line = 1'b0
);
   task automatic send_cmd(input logic [7:0] b);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_byte = b;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      cmd_byte = ~b;
   endtask
   task automatic send_data(input logic [7:0] b, input logic e);
      @(negedge sys_clk);
      byte_accepted = 1'b1;
      data_in_byte = b;
      eoi_line = e;
      @(negedge sys_clk);
      byte_accepted = 1'b0;
      data_in_byte = ~b;
      eoi_line = 1'b0;
   endtask
endmodule

/* File: tb/test_bame_top.sv */
// Purpose: Self-checking bench for bame_top
// Assumes: clk_en held high
// Notes: Inputs change at falling edge
`timescale 1ns/10ps
module test_bame_top
   import bame_pkg::*;
;
   logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, chip_reset_cmd = 1'b0;
   logic reg_wr = 1'b0, out_valid = 1'b0, listener_addressed = 1'b0;
   logic talker_active = 1'b0, tpas_state = 1'b0, lpas_state = 1'b0;
   logic [8:0] reg_addr = 9'h000;
   logic [7:0] reg_wdata = 8'h00, auxiliary_reg_a = 8'h00;
   logic [7:0] data_out_byte = 8'h00, cmd_byte, data_in_byte;
   logic [1:0] addr_mode = 2'h1;
   logic cmd_valid, byte_accepted, eoi_line, major_talk_match;
   logic major_listen_match, minor_talk_match, minor_listen_match;
   logic secondary_talk_match, secondary_listen_match;
   logic end_flag_set, eoi_n_out;
   logic [7:0] first_address_slot, second_address_slot;
   int fail_count = 0, tests_run = 0, cyc = 0;
   bame_top dut (.*);
   bame_bus_model bm (.*);
   initial forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic mc(input logic [1:0] m, input logic t, l,
      input logic [7:0] b, input logic [5:0] e);
      addr_mode = m;
      tpas_state = t;
      lpas_state = l;
      bm.send_cmd(b);
      chk("match", {2'h0, e}, {2'h0, major_talk_match, major_listen_match,
         minor_talk_match, minor_listen_match, secondary_talk_match,
         secondary_listen_match});
   endtask
   task automatic rx(input logic [7:0] d, input logic e, f);
      bm.send_data(d, e);
      chk("end", {7'h0, f}, {7'h0, end_flag_set});
   endtask
   task automatic tx(input logic [7:0] d, input logic e);
      @(negedge sys_clk);
      out_valid = 1'b1;
      data_out_byte = d;
      @(negedge sys_clk);
      out_valid = 1'b0;
      data_out_byte = ~d;
      chk("eoi", {7'h0, e}, {7'h0, eoi_n_out});
   endtask
   initial begin
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      chk("slot0", {1'b0, BAME_SLOT_RESET}, first_address_slot);
      chk("slot1", {1'b0, BAME_SLOT_RESET}, second_address_slot);
      wr(BAME_OFF_ADDR_LOAD, 8'h05);
      wr(BAME_OFF_ADDR_LOAD, 8'hc3);
      @(negedge sys_clk);
      chk("slot0", 8'h05, first_address_slot);
      chk("slot1", 8'h43, second_address_slot);
      mc(2'h1, 1'b0, 1'b0, 8'h45, 6'h20);
      mc(2'h1, 1'b0, 1'b0, 8'h25, 6'h10);
      mc(2'h1, 1'b0, 1'b0, 8'h23, 6'h04);
      mc(2'h1, 1'b0, 1'b0, 8'h43, 6'h00);
      mc(2'h3, 1'b0, 1'b0, 8'h23, 6'h04);
      wr(BAME_OFF_ADDR_LOAD, 8'h45);
      mc(2'h2, 1'b0, 1'b1, 8'h23, 6'h00);
      mc(2'h2, 1'b0, 1'b1, 8'ha3, 6'h01);
      mc(2'h2, 1'b0, 1'b0, 8'ha3, 6'h00);
      mc(2'h2, 1'b1, 1'b0, 8'ha3, 6'h00);
      wr(BAME_OFF_ADDR_LOAD, 8'ha3);
      wr(BAME_OFF_ADDR_LOAD, 8'h25);
      mc(2'h2, 1'b1, 1'b0, 8'ha3, 6'h02);
      mc(2'h2, 1'b0, 1'b1, 8'ha3, 6'h00);
      wr(BAME_OFF_ADDR_LOAD, 8'h45);
      mc(2'h1, 1'b0, 1'b0, 8'h45, 6'h00);
      mc(2'h1, 1'b0, 1'b0, 8'h25, 6'h10);
      $display("address tests done");
      wr(BAME_OFF_EOS_BYTE, 8'h8a);
      listener_addressed = 1'b1;
      auxiliary_reg_a = 8'h04;
      rx(8'h0a, 1'b1, 1'b1);
      @(negedge sys_clk);
      chk("slot1", 8'ha3, second_address_slot);
      auxiliary_reg_a = 8'h14;
      rx(8'h0a, 1'b0, 1'b0);
      rx(8'h8a, 1'b1, 1'b1);
      chip_reset_cmd = 1'b1;
      @(negedge sys_clk);
      chip_reset_cmd = 1'b0;
      @(negedge sys_clk);
      chk("slot1", 8'h23, second_address_slot);
      talker_active = 1'b1;
      auxiliary_reg_a = 8'h18;
      tx(8'h8a, 1'b0);
      tx(8'h0a, 1'b1);
      auxiliary_reg_a = 8'h08;
      tx(8'h0a, 1'b0);
      $display("string tests done");
      wr(BAME_OFF_ADDR_LOAD, 8'he3);
      mc(2'h1, 1'b0, 1'b0, 8'h23, 6'h00);
      mc(2'h1, 1'b0, 1'b0, 8'h43, 6'h00);
      $display("single address test done");
      test_done();
   end
endmodule
